// File: hw/hs_startup_seq.sv
// Start-up sequencer of the hot-swap device with its management registers.
//
// Functional notes
// - Internal 3.3V rail follows input threshold only.
// - Regular mode keeps bus and control alive.
// - Low-power bit plus enable low sleeps.
// - Enable gates the on output.
// - Slaves follow on output; device sets sequence.
// - Fault-ok high once rail is good.
// - Copy nvm image, then init delay.
// - Init delay starts converters, on held low.
// - Drive limit references after init delay.
// - Bus silent until address sampled.
// - Low-power state entered after init delay.
// - Enable rise with on command starts wait.
// - No turn-on wait without on command.
// - Wait expiry raises on, starts insertion.
// - Insertion end starts gate and soft start.
// - Soft start over threshold selects warn level.
// - Power good only in good function.
// - Reload bit picks copy or immediate wait.
`timescale 1ns/100ps
module hs_startup_seq (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Supplies and straps
  input  wire logic        I_VIN_OK,
  input  wire logic        I_RAIL_OK,
  input  wire logic        I_EN,
  input  wire logic [6:0]  I_ADDR_SAMPLE,
  input  wire logic        I_ADDR_VALID,
  // Analog status, pin-function select and turn-on wait
  input  wire logic        I_SS_ABOVE_TH,
  input  wire logic        I_VOUT_PG,
  input  wire logic        I_PG_SELECT,
  input  wire logic [23:0] I_TON_WAIT_CYC,
  // Nonvolatile image read port
  output logic [1:0]       O_NVM_ADDR,
  input  wire logic [15:0] I_NVM_DATA,
  // Management register port
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [15:0] I_REG_WDATA,
  output logic [15:0]      O_REG_RDATA,
  output logic             O_REG_ACK,
  output logic [6:0]       O_BUS_ADDR,
  output logic             O_BUS_LIVE,
  // Power stage and pins
  output logic             O_RAIL_EN,
  output logic             O_ADC_EN,
  output logic             O_CTRL_EN,
  output logic             O_ON,
  output logic             O_GATE_CHARGE,
  output logic             O_SS_EN,
  output logic             O_REF_EN,
  output logic [3:0]       O_CURRENT_LIMIT_REF,
  output logic [3:0]       O_COMBINED_LIMIT_REF,
  output logic             O_FAULT_OK,
  output logic             O_POWER_GOOD,
  output logic             O_LOW_POWER
);

  typedef struct packed {
    hs_seq_pkg::seq_state_t st;
    logic [23:0] cnt;
    logic [1:0]  nvm_idx;
    logic [7:0]  operation;
    logic [7:0]  ref_level;
    logic [7:0]  init_delay;
    logic [15:0] adv_ctrl;
    logic        en_d;
    logic        addr_ok;
    logic [6:0]  bus_addr;
    logic        warn_sel;
    logic        refs_on;
    logic [15:0] rdata;
    logic        ack;
    logic        pg;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Writes one register word into the state copy; used by the bus and the image load.
  function automatic state_t reg_write(state_t s, logic [7:0] a, logic [15:0] d);
    state_t t;
    t = s;
    unique case (a)
      hs_seq_pkg::ADDR_OPERATION:  t.operation  = d[7:0];
      hs_seq_pkg::ADDR_REF_LEVEL:  t.ref_level  = d[7:0];
      hs_seq_pkg::ADDR_INIT_DELAY: t.init_delay = d[7:0];
      hs_seq_pkg::ADDR_ADV_CTRL:   t.adv_ctrl   = d;
      default: t = s;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] nvm_target(logic [1:0] i);
    logic [7:0] a;
    a = hs_seq_pkg::ADDR_OPERATION;
    unique case (i)
      2'h0: a = hs_seq_pkg::ADDR_OPERATION;
      2'h1: a = hs_seq_pkg::ADDR_REF_LEVEL;
      2'h2: a = hs_seq_pkg::ADDR_INIT_DELAY;
      2'h3: a = hs_seq_pkg::ADDR_ADV_CTRL;
    endcase
    return a;
  endfunction

  logic en_rise;
  logic on_cmd;
  logic lpm_cfg;
  logic [23:0] init_cyc;

  always_comb begin
    en_rise  = I_EN && !s_r.en_d;
    on_cmd   = (s_r.operation == hs_seq_pkg::OPERATION_ON);
    lpm_cfg  = s_r.adv_ctrl[hs_seq_pkg::ADV_LPM_BIT];
    init_cyc = 24'(s_r.init_delay) * 24'(hs_seq_pkg::INIT_STEP_CYC);
    s_nxt = s_r;
    s_nxt.en_d = I_EN;
    s_nxt.ack = 1'b0;
    s_nxt.cnt = s_r.cnt + 24'h000001;

    // Bus is refused until the address is sampled.
    if (!s_r.addr_ok && I_ADDR_VALID && s_r.refs_on) begin
      s_nxt.addr_ok  = 1'b1;
      s_nxt.bus_addr = I_ADDR_SAMPLE;
    end
    // Register access stays live in every mode, low power included.
    if (s_r.addr_ok && (I_REG_WR || I_REG_RD)) begin
      s_nxt.ack = 1'b1;
      if (I_REG_WR) begin
        s_nxt = reg_write(s_nxt, I_REG_ADDR, I_REG_WDATA);
      end
      unique case (I_REG_ADDR)
        hs_seq_pkg::ADDR_OPERATION:  s_nxt.rdata = {8'h00, s_r.operation};
        hs_seq_pkg::ADDR_REF_LEVEL:  s_nxt.rdata = {8'h00, s_r.ref_level};
        hs_seq_pkg::ADDR_INIT_DELAY: s_nxt.rdata = {8'h00, s_r.init_delay};
        hs_seq_pkg::ADDR_ADV_CTRL:   s_nxt.rdata = s_r.adv_ctrl;
        default:                     s_nxt.rdata = 16'h0000;
      endcase
    end

    unique case (s_r.st)
      hs_seq_pkg::ST_RESET: begin
        if (I_RAIL_OK) begin
          s_nxt.st = hs_seq_pkg::ST_COPY;
          s_nxt.nvm_idx = 2'h0;
        end
      end
      hs_seq_pkg::ST_COPY: begin
        s_nxt = reg_write(s_nxt, nvm_target(s_r.nvm_idx), I_NVM_DATA);
        s_nxt.nvm_idx = s_r.nvm_idx + 2'h1;
        s_nxt.cnt = 24'h000000;
        if (s_r.nvm_idx == 2'(hs_seq_pkg::NVM_WORDS - 1)) begin
          s_nxt.st = hs_seq_pkg::ST_INIT;
        end
      end
      hs_seq_pkg::ST_INIT: begin
        if (s_r.cnt >= init_cyc) begin
          s_nxt.refs_on = 1'b1;
          s_nxt.warn_sel = 1'b0;
          s_nxt.st = (lpm_cfg && !I_EN) ? hs_seq_pkg::ST_LOW_POWER : hs_seq_pkg::ST_IDLE;
        end
      end
      hs_seq_pkg::ST_IDLE: begin
        s_nxt.cnt = 24'h000000;
        if (en_rise && on_cmd) begin
          s_nxt.st = hs_seq_pkg::ST_TON;
        end else if (lpm_cfg && !I_EN) begin
          s_nxt.st = hs_seq_pkg::ST_LOW_POWER;
        end
      end
      hs_seq_pkg::ST_LOW_POWER: begin
        s_nxt.cnt = 24'h000000;
        s_nxt.nvm_idx = 2'h0;
        if (en_rise) begin
          if (s_r.adv_ctrl[hs_seq_pkg::ADV_RELOAD_BIT]) begin
            s_nxt.st = hs_seq_pkg::ST_COPY;
          end else if (on_cmd) begin
            s_nxt.st = hs_seq_pkg::ST_TON;
          end else begin
            s_nxt.st = hs_seq_pkg::ST_IDLE;
          end
        end
      end
      hs_seq_pkg::ST_TON: begin
        if (!I_EN || !on_cmd) begin
          s_nxt.st = hs_seq_pkg::ST_IDLE;
        end else if (s_r.cnt + 24'h000001 >= I_TON_WAIT_CYC) begin
          s_nxt.st = hs_seq_pkg::ST_INSERT;
          s_nxt.cnt = 24'h000000;
        end
      end
      hs_seq_pkg::ST_INSERT: begin
        if (!I_EN || !on_cmd) begin
          s_nxt.st = hs_seq_pkg::ST_IDLE;
        end else if (s_r.cnt + 24'h000001 >= 24'(hs_seq_pkg::INSERT_DELAY_CYC)) begin
          s_nxt.st = hs_seq_pkg::ST_SOFT;
        end
      end
      hs_seq_pkg::ST_SOFT, hs_seq_pkg::ST_RUN: begin
        if (!I_EN || !on_cmd) begin
          s_nxt.st = hs_seq_pkg::ST_IDLE;
          s_nxt.warn_sel = 1'b0;
        end else if (I_SS_ABOVE_TH) begin
          s_nxt.warn_sel = 1'b1;
          s_nxt.st = hs_seq_pkg::ST_RUN;
        end
      end
    endcase
    // Power good only when the shared pin serves that function.
    s_nxt.pg = (s_nxt.st == hs_seq_pkg::ST_RUN || s_nxt.st == hs_seq_pkg::ST_SOFT)
               && I_VOUT_PG && I_PG_SELECT;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= '{st: hs_seq_pkg::ST_RESET, cnt: 24'h000000, nvm_idx: 2'h0,
               operation: hs_seq_pkg::OPERATION_RST, ref_level: hs_seq_pkg::REF_LEVEL_RST,
               init_delay: hs_seq_pkg::INIT_DELAY_RST, adv_ctrl: hs_seq_pkg::ADV_CTRL_RST,
               en_d: 1'b0, addr_ok: 1'b0, bus_addr: 7'h00, warn_sel: 1'b0,
               refs_on: 1'b0, rdata: 16'h0000, ack: 1'b0, pg: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  logic on_state;
  always_comb begin
    on_state = (s_r.st == hs_seq_pkg::ST_INSERT) || (s_r.st == hs_seq_pkg::ST_SOFT)
               || (s_r.st == hs_seq_pkg::ST_RUN);
    O_RAIL_EN     = I_VIN_OK;
    O_FAULT_OK    = I_RAIL_OK;
    O_ON          = on_state && I_EN;
    O_GATE_CHARGE = O_ON && (s_r.st != hs_seq_pkg::ST_INSERT);
    O_SS_EN       = O_GATE_CHARGE;
    O_ADC_EN      = (s_r.st != hs_seq_pkg::ST_RESET) && (s_r.st != hs_seq_pkg::ST_COPY)
                    && (s_r.st != hs_seq_pkg::ST_LOW_POWER);
    O_CTRL_EN     = (s_r.st != hs_seq_pkg::ST_LOW_POWER);
    O_LOW_POWER   = (s_r.st == hs_seq_pkg::ST_LOW_POWER);
    O_REF_EN      = s_r.refs_on;
    O_CURRENT_LIMIT_REF = s_r.refs_on ?
      s_r.ref_level[hs_seq_pkg::REF_SC_LSB +: hs_seq_pkg::REF_FIELD_W] : 4'h0;
    O_COMBINED_LIMIT_REF = !s_r.refs_on ? 4'h0 : s_r.warn_sel ?
      s_r.ref_level[hs_seq_pkg::REF_WARN_LSB +: hs_seq_pkg::REF_FIELD_W] :
      s_r.ref_level[hs_seq_pkg::REF_SC_LSB +: hs_seq_pkg::REF_FIELD_W];
    O_POWER_GOOD  = s_r.pg;
    O_REG_RDATA   = s_r.rdata;
    O_REG_ACK     = s_r.ack;
    O_BUS_ADDR    = s_r.bus_addr;
    O_BUS_LIVE    = s_r.addr_ok;
    O_NVM_ADDR    = s_r.nvm_idx;
  end

endmodule

// File: hw/hs_seq_pkg.sv
// Constants and types shared by the hot-swap start-up sequencer.
package hs_seq_pkg;
  // Register codes of the management command port.
  localparam logic [7:0] ADDR_OPERATION   = 8'h01;
  localparam logic [7:0] ADDR_REF_LEVEL   = 8'hC5;
  localparam logic [7:0] ADDR_INIT_DELAY  = 8'hD0;
  localparam logic [7:0] ADDR_ADV_CTRL    = 8'hF1;
  // Reset values and the on-command code.
  localparam logic [7:0]  OPERATION_RST   = 8'h80;
  localparam logic [7:0]  OPERATION_ON    = 8'h80;
  localparam logic [7:0]  REF_LEVEL_RST   = 8'h00;
  localparam logic [7:0]  INIT_DELAY_RST  = 8'h00;
  localparam logic [15:0] ADV_CTRL_RST    = 16'h0000;
  // Field positions.
  localparam int ADV_LPM_BIT    = 12;
  localparam int ADV_RELOAD_BIT = 13;
  localparam int REF_SC_LSB     = 0;
  localparam int REF_WARN_LSB   = 4;
  localparam int REF_FIELD_W    = 4;
  // Timing: one init-delay step and the insertion delay; counter width and image word count.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int INIT_STEP_US     = 1;
  localparam int INIT_STEP_CYC    = (INIT_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INSERT_DELAY_US  = 20;
  localparam int INSERT_DELAY_CYC =
    (INSERT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int NVM_WORDS = 4;

  typedef enum logic [3:0] {
    ST_RESET, ST_COPY, ST_INIT, ST_IDLE, ST_LOW_POWER, ST_TON, ST_INSERT, ST_SOFT, ST_RUN
  } seq_state_t;
endpackage

// File: test/hs_seq_sva.sv
// Port-level assertions of the hot-swap start-up sequencer.
`timescale 1ns/100ps
module hs_seq_sva (
  // Sequencer inputs
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_RAIL_OK,
  input wire logic I_EN,
  input wire logic I_ADDR_VALID,
  input wire logic I_VOUT_PG,
  input wire logic I_PG_SELECT,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  // Sequencer outputs
  input wire logic O_REG_ACK,
  input wire logic O_BUS_LIVE,
  input wire logic O_ON,
  input wire logic O_GATE_CHARGE,
  input wire logic O_FAULT_OK,
  input wire logic O_POWER_GOOD
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  fault_ok_a: assert property (O_FAULT_OK == I_RAIL_OK)
    else $error("fault ok wrong");
  on_gated_a: assert property (!I_EN |-> !O_ON)
    else $error("on without enable");
  dead_bus_a: assert property ((I_REG_WR || I_REG_RD) && !O_BUS_LIVE |=> !O_REG_ACK)
    else $error("ack before address");
  live_ack_a: assert property ((I_REG_WR || I_REG_RD) && O_BUS_LIVE |=> O_REG_ACK)
    else $error("no ack");
  addr_first_a: assert property ($rose(O_BUS_LIVE) |-> $past(I_ADDR_VALID))
    else $error("live without address");
  gate_on_a: assert property (O_GATE_CHARGE |-> O_ON)
    else $error("gate without on");
  insert_hold_a: assert property ($rose(O_ON) |=> !O_GATE_CHARGE [*8])
    else $error("no insertion delay");
  pg_cause_a: assert property ($rose(O_POWER_GOOD) |-> $past(I_VOUT_PG) && $past(I_PG_SELECT))
    else $error("power good without cause");
endmodule

// File: test/hs_far_model.sv
// Far side: image memory, soft-start ramp and one paralleled slave.
`timescale 1ns/100ps
module hs_far_model (
  // Sequencer side
  input  wire logic       i_clk,
  input  wire logic [1:0] i_nvm_addr,
  input  wire logic       i_on,
  input  wire logic       i_gate,
  // Model outputs
  output logic [15:0]     o_nvm_data,
  output logic            o_ss_above,
  output logic            o_vout_pg,
  output logic            o_slave_on
);
  logic [7:0] ramp = 8'h00;
  always_comb begin
    case (i_nvm_addr)
      2'h0: o_nvm_data = 16'h0080;
      2'h1: o_nvm_data = 16'h00A3;
      2'h2: o_nvm_data = 16'h0002;
      default: o_nvm_data = 16'h0000;
    endcase
  end
  // The capacitor is discharged whenever gate drive stops, so the ramp restarts.
  always_ff @(posedge i_clk) begin
    if (!i_gate) ramp <= 8'h00;
    else if (ramp != 8'hFF) ramp <= ramp + 8'h01;
  end
  assign o_ss_above = ramp > 8'h10;
  assign o_vout_pg  = ramp > 8'h20;
  assign o_slave_on = i_on;
endmodule

// File: test/hs_startup_seq_tb.sv
// Self-checking bench of the hot-swap start-up sequencer.
`timescale 1ns/100ps
module hs_startup_seq_tb;
  logic        clk, rst_n, vin, rail, en, av, psel, wr, rd, k;
  logic [7:0]  ra;
  logic [6:0]  sa;
  logic [15:0] wd, q;
  logic [23:0] ton;
  logic [7:0]  adr [5] = '{8'h01, 8'hC5, 8'hD0, 8'hF1, 8'h00};
  logic [15:0] exr [5] = '{16'h0080, 16'h00A3, 16'h0002, 16'h0000, 16'h0000};
  wire logic [15:0] rdat, nvd;
  wire logic [1:0]  na;
  wire logic [6:0]  ba;
  wire logic [3:0]  cl, cb;
  wire logic ack, live, on, gate, ss, pg, vpg, son, lp, ctl, fok, refe, rle, adc, sse;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  hs_startup_seq i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_VIN_OK(vin), .I_RAIL_OK(rail),
    .I_EN(en), .I_ADDR_SAMPLE(sa), .I_ADDR_VALID(av), .I_SS_ABOVE_TH(ss),
    .I_VOUT_PG(vpg), .I_PG_SELECT(psel), .I_TON_WAIT_CYC(ton), .O_NVM_ADDR(na),
    .I_NVM_DATA(nvd), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(ra), .I_REG_WDATA(wd),
    .O_REG_RDATA(rdat), .O_REG_ACK(ack), .O_BUS_ADDR(ba), .O_BUS_LIVE(live),
    .O_RAIL_EN(rle), .O_ADC_EN(adc), .O_CTRL_EN(ctl), .O_ON(on), .O_GATE_CHARGE(gate),
    .O_SS_EN(sse), .O_REF_EN(refe), .O_CURRENT_LIMIT_REF(cl), .O_COMBINED_LIMIT_REF(cb),
    .O_FAULT_OK(fok), .O_POWER_GOOD(pg), .O_LOW_POWER(lp));
  hs_far_model i_far (.i_clk(clk), .i_nvm_addr(na), .i_on(on), .i_gate(gate),
    .o_nvm_data(nvd), .o_ss_above(ss), .o_vout_pg(vpg), .o_slave_on(son));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Strobe for one cycle; the answer stands in the cycle after the taking edge.
  task automatic rw(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdat;
    k = ack;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return on;
      1: return gate;
      2: return live;
      default: return refe;
    endcase
  endfunction
  task automatic wt(input int s, input int lim);
    n = 0;
    while (n < lim && pick(s) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    chk("wait", 16'h1, 16'(n < lim));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
  initial begin
    {rst_n, vin, rail, en, av, psel, wr, rd} = 8'h00;
    ra = 8'h00;
    sa = 7'h2B;
    wd = 16'h0000;
    ton = 24'h000005;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    vin <= 1'b1;
    rail <= 1'b1;
    psel <= 1'b1;
    rw(1'b0, 8'h01, 16'h0000);
    chk("early ack", 16'h0, 16'(k));
    chk("fault ok", 16'h1, 16'(fok));
    chk("rail enable", 16'h1, 16'(rle));
    chk("adc in copy", 16'h0, 16'(adc));
    wt(3, 400);
    chk("adc on", 16'h1, 16'(adc));
    chk("on in init", 16'h0, 16'(on));
    chk("limit ref", 16'h3, 16'(cl));
    chk("short ref", 16'h3, 16'(cb));
    @(posedge clk);
    av <= 1'b1;
    wt(2, 5);
    chk("bus addr", 16'h2B, 16'(ba));
    foreach (adr[i]) begin
      rw(1'b0, adr[i], 16'h0000);
      chk("copied reg", exr[i], q);
    end
    $display("start-up test done");
    @(posedge clk);
    en <= 1'b1;
    wt(0, 50);
    chk("turn-on wait", 16'h1, 16'(n >= 5));
    chk("slave on", 16'h1, 16'(son));
    wt(1, 2100);
    chk("insertion", 16'h1, 16'(n > 1995));
    chk("soft start", 16'h1, 16'(sse));
    repeat (40) @(posedge clk);
    #1 chk("warn ref", 16'hA, 16'(cb));
    chk("power good", 16'h1, 16'(pg));
    @(posedge clk);
    en <= 1'b0;
    ton <= 24'h000028;
    #1 chk("on gated", 16'h0, 16'(on));
    repeat (3) @(posedge clk);
    en <= 1'b1;
    #1 chk("control alive", 16'h1, 16'(ctl));
    repeat (10) @(posedge clk);
    en <= 1'b0;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    wt(0, 100);
    chk("wait restarted", 16'h1, 16'(n >= 40));
    $display("turn-on test done");
    @(posedge clk);
    en <= 1'b0;
    ton <= 24'h000005;
    rw(1'b1, 8'h01, 16'h0000);
    @(posedge clk);
    en <= 1'b1;
    repeat (60) @(posedge clk);
    #1 chk("no command", 16'h0, 16'(on));
    @(posedge clk);
    en <= 1'b0;
    rw(1'b1, 8'h01, 16'h0080);
    rw(1'b1, 8'hF1, 16'h1000);
    repeat (3) @(posedge clk);
    #1 chk("low power", 16'h1, 16'(lp));
    chk("control off", 16'h0, 16'(ctl));
    rw(1'b0, 8'hF1, 16'h0000);
    chk("adv ctrl", 16'h1000, q);
    @(posedge clk);
    en <= 1'b1;
    wt(0, 50);
    @(posedge clk);
    en <= 1'b0;
    rw(1'b1, 8'hF1, 16'h3000);
    repeat (3) @(posedge clk);
    #1 chk("low power again", 16'h1, 16'(lp));
    @(posedge clk);
    en <= 1'b1;
    repeat (300) @(posedge clk);
    #1 chk("left low power", 16'h0, 16'(lp));
    chk("no on after reload", 16'h0, 16'(on));
    rw(1'b0, 8'hF1, 16'h0000);
    chk("image reloaded", 16'h0000, q);
    $display("low-power test done");
    test_done();
  end
endmodule
bind hs_startup_seq hs_seq_sva i_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_RAIL_OK(I_RAIL_OK), .I_EN(I_EN), .I_ADDR_VALID(I_ADDR_VALID), .I_VOUT_PG(I_VOUT_PG),
  .I_PG_SELECT(I_PG_SELECT), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_ACK(O_REG_ACK), .O_BUS_LIVE(O_BUS_LIVE), .O_ON(O_ON),
  .O_GATE_CHARGE(O_GATE_CHARGE), .O_FAULT_OK(O_FAULT_OK), .O_POWER_GOOD(O_POWER_GOOD));
